// [rtl/mwf_params.svh]
// Constants for the mixed-width dual-clock FIFO block
// Function
// - Write and read widths may differ only by a power-of-two ratio.
// - Both orientations work: wide write with narrow read, and the reverse.
// - Sixteen-bit write, eight-bit read: two writes show counts two and four.
// - A wide word leaves a narrow read port low slice first, high slice next.
// - Eight-bit write, sixteen-bit read: four writes show counts four and two.
// - Narrow words pack into a wide read word, first written in low part.
// - Read-side empty holds until a whole read word has been written.
// - Write pointer reaches the read side through a synchroniser chain.
// - Read pointer reaches the write side through a synchroniser chain.
// - Clear returns both read and write pointers to zero.
// - Crossing pointers are Gray coded, one bit changing per step.
`ifndef MWF_PARAMS_SVH
`define MWF_PARAMS_SVH

// ==========================================
// Register offsets
`define MWF_OFS_WDATA 8'h00
`define MWF_OFS_RDATA 8'h04
`define MWF_OFS_STATUS 8'h08
`define MWF_OFS_ISTAT 8'h0C
`define MWF_OFS_IMASK 8'h10
`define MWF_OFS_CTRL 8'h14

// ==========================================
// Field positions
`define MWF_ST_RD_EMPTY 0
`define MWF_ST_WR_FULL 1
`define MWF_ST_WR_EMPTY 2
`define MWF_ST_RD_FULL 3
`define MWF_ST_WR_USED 8
`define MWF_ST_RD_USED 16
`define MWF_EV_DATA 0
`define MWF_EV_FULL 1
`define MWF_EV_OVF 2
`define MWF_EV_UNF 3
`define MWF_NEV 4
`define MWF_CTRL_CLR 0

// ==========================================
// Reset values
`define MWF_IMASK_RST 4'h0
`define MWF_ISTAT_RST 4'h0

`endif

// [rtl/mwf_pkg.sv]
// Types shared by the mixed-width FIFO modules
package mwf_pkg;
   typedef enum logic {BS_IDLE, BS_ACT} mwf_bus_st_t;
   typedef logic [31:0] mwf_word_t;
   typedef logic [1:0] mwf_trans_t;
   typedef logic [2:0] mwf_size_t;
endpackage

// [rtl/mwf_mem.sv]
// Storage array of narrow units and its access interface
`timescale 1ns/1ps

// ==========================================
// Access interface
interface mwf_mem_if #(parameter int N = 8, parameter int WK = 2, parameter int RK = 1, parameter int AWU = 4)
   (input logic clk);
   logic wr_en;
   logic [AWU-1:0] wr_addr;
   logic [N*WK-1:0] wr_data;
   logic [AWU-1:0] rd_addr;
   logic [N*RK-1:0] rd_data;
   modport ctl (input clk, output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem (input clk, input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ==========================================
// Storage
module mwf_mem #(
   parameter int N = 8,
   parameter int WK = 2,
   parameter int RK = 1,
   parameter int AWU = 4
) (
   mwf_mem_if.mem bus
);
   // No reset: contents are only read behind a valid pointer
   logic [N-1:0] mem_q [2**AWU];

   always_ff @(posedge bus.clk) begin
      if (bus.wr_en) begin
         for (int k = 0; k < WK; k++) begin
            mem_q[bus.wr_addr | AWU'(k)] <= bus.wr_data[k*N +: N];
         end
      end
   end

   // Unit at the lower address lands in the low slice
   for (genvar g = 0; g < RK; g++) begin : g_rd
      assign bus.rd_data[g*N +: N] = mem_q[bus.rd_addr | AWU'(g)];
   end
endmodule // mwf_mem

// [rtl/mwf_top.sv]
// Mixed-width FIFO with AHB-Lite register access and interrupt
`timescale 1ns/1ps
`include "mwf_params.svh"

module mwf_top #(
   parameter int WR_W = 16,
   parameter int RD_W = 8,
   parameter int DEPTH_U = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire mwf_pkg::mwf_word_t haddr,
   input wire mwf_pkg::mwf_trans_t htrans,
   input wire logic hwrite,
   input wire mwf_pkg::mwf_size_t hsize,
   input wire mwf_pkg::mwf_word_t hwdata,
   input wire logic hready,
   output logic hreadyout,
   output mwf_pkg::mwf_word_t hrdata,
   output logic hresp,
   output logic irq
);
   import mwf_pkg::*;

   // ==========================================
   // Geometry
   localparam int N = (WR_W < RD_W) ? WR_W : RD_W;
   localparam int WK = WR_W / N;
   localparam int RK = RD_W / N;
   localparam int LWK = $clog2(WK);
   localparam int LRK = $clog2(RK);
   localparam int AWU = $clog2(DEPTH_U);
   localparam int AWW = AWU - LWK;
   localparam int AWR = AWU - LRK;
   localparam bit RATIO_OK = (WK * N == WR_W) && (RK * N == RD_W) && ((WK & (WK - 1)) == 0)
      && ((RK & (RK - 1)) == 0) && (WR_W <= 32) && (RD_W <= 32) && ((1 << AWU) == DEPTH_U)
      && (AWU < 8) && (DEPTH_U >= WK) && (DEPTH_U >= RK);
   localparam logic [AWU:0] WK_U = (AWU+1)'(WK);
   localparam logic [AWU:0] RK_U = (AWU+1)'(RK);
   localparam logic [AWU:0] DEP_U = (AWU+1)'(DEPTH_U);

   function automatic logic [AWU:0] g2b(input logic [AWU:0] g);
      logic [AWU:0] b;
      b = g;
      for (int i = AWU - 1; i >= 0; i--) begin
         b[i] = b[i + 1] ^ g[i];
      end
      return b;
   endfunction

   // ==========================================
   // Declarations
   mwf_bus_st_t bs_ff;
   logic hreadyout_ff;
   logic hresp_ff;
   logic irq_ff;
   mwf_word_t hrdata_ff;
   logic wr_ff;
   logic [7:0] addr_ff;
   logic [AWW:0] wptr_ff;
   logic [AWW:0] wgray_ff;
   logic [AWR:0] rptr_ff;
   logic [AWR:0] rgray_ff;
   logic [AWU:0] rs_w1_ff;
   logic [AWU:0] read_side_write_pointer_sync_ff;
   logic [AWU:0] ws_r1_ff;
   logic [AWU:0] write_side_read_pointer_sync_ff;
   logic [`MWF_NEV-1:0] istat_ff;
   logic [`MWF_NEV-1:0] mask_ff;
   logic rd_empty_q_ff;
   logic wr_full_q_ff;
   logic [AWW:0] nxt_wptr;
   logic [AWR:0] nxt_rptr;
   logic [AWU:0] wu;
   logic [AWU:0] wr_ru;
   logic [AWU:0] wr_diff;
   logic [AWU:0] wr_used;
   logic [AWU:0] rd_wu;
   logic [AWU:0] ru;
   logic [AWU:0] rd_diff;
   logic [AWU:0] rd_used;
   logic wr_full;
   logic wr_empty;
   logic rd_full;
   logic rd_empty;
   logic acc;
   logic act;
   logic do_push;
   logic do_pop;
   logic do_clr;
   logic ovf;
   logic unf;
   logic rd_istat;
   logic [`MWF_NEV-1:0] ev;
   mwf_word_t stat_w;

   mwf_mem_if #(.N(N), .WK(WK), .RK(RK), .AWU(AWU)) mem_if (.clk(hclk));
   mwf_mem #(.N(N), .WK(WK), .RK(RK), .AWU(AWU)) u_mem (
      .bus(mem_if.mem)
   );

   // ==========================================
   // Bus slave
   // One wait state so read data and pops come from a clean registered decode
   assign acc = hsel && hready && htrans[1] && (hsize == 3'h2) && (bs_ff == BS_IDLE);
   assign act = (bs_ff == BS_ACT);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bs_ff <= BS_IDLE;
         hreadyout_ff <= 1'b1;
         wr_ff <= 1'b0;
         addr_ff <= 8'h00;
      end else begin
         unique case (bs_ff)
            BS_IDLE: begin
               if (acc) begin
                  bs_ff <= BS_ACT;
                  hreadyout_ff <= 1'b0;
                  wr_ff <= hwrite;
                  addr_ff <= haddr[7:0];
               end
            end
            BS_ACT: begin
               bs_ff <= BS_IDLE;
               hreadyout_ff <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp_ff <= 1'b0;
      end else begin
         hresp_ff <= 1'b0;
      end
   end

   // ==========================================
   // Access decode
   assign do_push = act && wr_ff && (addr_ff == `MWF_OFS_WDATA) && !wr_full && RATIO_OK;
   assign ovf = act && wr_ff && (addr_ff == `MWF_OFS_WDATA) && wr_full;
   assign do_pop = act && !wr_ff && (addr_ff == `MWF_OFS_RDATA) && !rd_empty;
   assign unf = act && !wr_ff && (addr_ff == `MWF_OFS_RDATA) && rd_empty;
   assign do_clr = act && wr_ff && (addr_ff == `MWF_OFS_CTRL) && hwdata[`MWF_CTRL_CLR];
   assign rd_istat = act && !wr_ff && (addr_ff == `MWF_OFS_ISTAT);

   assign mem_if.wr_en = do_push;
   assign mem_if.wr_addr = wu[AWU-1:0];
   assign mem_if.wr_data = hwdata[WR_W-1:0];
   assign mem_if.rd_addr = ru[AWU-1:0];

   // ==========================================
   // Pointers
   assign nxt_wptr = wptr_ff + 1'b1;
   assign nxt_rptr = rptr_ff + 1'b1;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wptr_ff <= '0;
         wgray_ff <= '0;
      end else if (do_clr) begin
         wptr_ff <= '0;
         wgray_ff <= '0;
      end else if (do_push) begin
         wptr_ff <= nxt_wptr;
         wgray_ff <= nxt_wptr ^ (nxt_wptr >> 1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rptr_ff <= '0;
         rgray_ff <= '0;
      end else if (do_clr) begin
         rptr_ff <= '0;
         rgray_ff <= '0;
      end else if (do_pop) begin
         rptr_ff <= nxt_rptr;
         rgray_ff <= nxt_rptr ^ (nxt_rptr >> 1);
      end
   end

   // ==========================================
   // Pointer synchronisers
   // Chains are cleared with the pointers so no stale count survives a clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rs_w1_ff <= '0;
         read_side_write_pointer_sync_ff <= '0;
         ws_r1_ff <= '0;
         write_side_read_pointer_sync_ff <= '0;
      end else if (do_clr) begin
         rs_w1_ff <= '0;
         read_side_write_pointer_sync_ff <= '0;
         ws_r1_ff <= '0;
         write_side_read_pointer_sync_ff <= '0;
      end else begin
         rs_w1_ff <= (AWU+1)'(wgray_ff);
         read_side_write_pointer_sync_ff <= rs_w1_ff;
         ws_r1_ff <= (AWU+1)'(rgray_ff);
         write_side_read_pointer_sync_ff <= ws_r1_ff;
      end
   end

   // ==========================================
   // Fill levels, each in its own word size
   // Pointers count own-size words so Gray steps stay single-bit
   assign wu = (AWU+1)'(wptr_ff) << LWK;
   assign wr_ru = g2b(write_side_read_pointer_sync_ff) << LRK;
   assign wr_diff = wu - wr_ru;
   assign wr_used = (wr_diff + WK_U - 1'b1) >> LWK;
   assign wr_full = wr_diff > (DEP_U - WK_U);
   assign wr_empty = (wr_diff == '0);

   assign ru = (AWU+1)'(rptr_ff) << LRK;
   assign rd_wu = g2b(read_side_write_pointer_sync_ff) << LWK;
   assign rd_diff = rd_wu - ru;
   assign rd_used = rd_diff >> LRK;
   assign rd_empty = rd_diff < RK_U;
   assign rd_full = rd_diff > (DEP_U - RK_U);

   always_comb begin
      stat_w = 32'h0000_0000;
      stat_w[`MWF_ST_RD_EMPTY] = rd_empty;
      stat_w[`MWF_ST_WR_FULL] = wr_full;
      stat_w[`MWF_ST_WR_EMPTY] = wr_empty;
      stat_w[`MWF_ST_RD_FULL] = rd_full;
      stat_w[`MWF_ST_WR_USED +: 8] = 8'(wr_used);
      stat_w[`MWF_ST_RD_USED +: 8] = 8'(rd_used);
   end

   // ==========================================
   // Read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (act && !wr_ff) begin
         case (addr_ff)
            `MWF_OFS_RDATA: hrdata_ff <= rd_empty ? 32'h0000_0000 : 32'(mem_if.rd_data);
            `MWF_OFS_STATUS: hrdata_ff <= stat_w;
            `MWF_OFS_ISTAT: hrdata_ff <= 32'(istat_ff);
            `MWF_OFS_IMASK: hrdata_ff <= 32'(mask_ff);
            default: hrdata_ff <= 32'h0000_0000;
         endcase
      end else begin
         hrdata_ff <= 32'h0000_0000;
      end
   end

   // ==========================================
   // Interrupts
   always_comb begin
      ev = '0;
      ev[`MWF_EV_DATA] = rd_empty_q_ff && !rd_empty;
      ev[`MWF_EV_FULL] = wr_full && !wr_full_q_ff;
      ev[`MWF_EV_OVF] = ovf;
      ev[`MWF_EV_UNF] = unf;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_empty_q_ff <= 1'b1;
         wr_full_q_ff <= 1'b0;
      end else begin
         rd_empty_q_ff <= rd_empty;
         wr_full_q_ff <= wr_full;
      end
   end

   // Set beats a clear-on-read in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         istat_ff <= `MWF_ISTAT_RST;
      end else begin
         istat_ff <= (istat_ff & ~{`MWF_NEV{rd_istat}}) | ev;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_ff <= `MWF_IMASK_RST;
      end else if (act && wr_ff && (addr_ff == `MWF_OFS_IMASK)) begin
         mask_ff <= hwdata[`MWF_NEV-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(istat_ff & mask_ff);
      end
   end

   assign hreadyout = hreadyout_ff;
   assign hrdata = hrdata_ff;
   assign hresp = hresp_ff;
   assign irq = irq_ff;
   // ==========================================
   // Assertions
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_ratio_legal: assert property (RATIO_OK)
      else $error("width pairing is not a power-of-two ratio");
   a_one_narrow_side: assert property (WK == 1 || RK == 1)
      else $error("neither port is the narrow one");
   a_fill_wide_write: assert property (
      (WK == 2 && RK == 1) ##0 ($stable(wptr_ff) && $stable(rptr_ff))[*3]
      ##0 (wptr_ff == 2 && rptr_ff == 0) |-> (wr_used == 2 && rd_used == 4))
      else $error("wide write counts not two and four");
   a_fill_narrow_write: assert property (
      (WK == 1 && RK == 2) ##0 ($stable(wptr_ff) && $stable(rptr_ff))[*3]
      ##0 (wptr_ff == 4 && rptr_ff == 0) |-> (wr_used == 4 && rd_used == 2))
      else $error("narrow write counts not four and two");
   a_empty_partial: assert property ((act && !wr_ff && (addr_ff == `MWF_OFS_RDATA) && (rd_diff < RK_U))
      |=> ($stable(rptr_ff) && istat_ff[`MWF_EV_UNF] && (hrdata_ff == 32'h0000_0000)))
      else $error("partial read word shown as available");
   a_wsync_lag: assert property (
      (!$past(do_clr) && !$past(do_clr, 2)) |-> read_side_write_pointer_sync_ff == $past(wgray_ff, 2))
      else $error("write pointer sync is not two stages");
   a_rsync_lag: assert property (
      (!$past(do_clr) && !$past(do_clr, 2)) |-> write_side_read_pointer_sync_ff == $past(rgray_ff, 2))
      else $error("read pointer sync is not two stages");
   a_clear_zero: assert property (do_clr |=> (wptr_ff == 0 && rptr_ff == 0 && wgray_ff == 0))
      else $error("clear left a pointer nonzero");
   a_gray_step_w: assert property (($changed(wgray_ff) && !$past(do_clr)) |-> $onehot(wgray_ff ^ $past(wgray_ff)))
      else $error("write gray pointer moved more than one bit");
   a_gray_step_r: assert property (($changed(rgray_ff) && !$past(do_clr)) |-> $onehot(rgray_ff ^ $past(rgray_ff)))
      else $error("read gray pointer moved more than one bit");
   a_full_ignore: assert property (ovf |=> ($stable(wptr_ff) && istat_ff[`MWF_EV_OVF]))
      else $error("write while full was not ignored");
   c_write_full: cover property (ovf);
   c_pop_to_empty: cover property (do_pop ##1 rd_empty);
   c_irq_rise: cover property ($rose(irq_ff));
endmodule // mwf_top

// [verif/mwf_master.sv]
// Bus master model standing for the producer and consumer logic
`timescale 1ns/1ps
`include "mwf_params.svh"

module mwf_master (
   input wire logic hclk,
   output logic hsel,
   output mwf_pkg::mwf_word_t haddr,
   output mwf_pkg::mwf_trans_t htrans,
   output logic hwrite,
   output mwf_pkg::mwf_size_t hsize,
   output mwf_pkg::mwf_word_t hwdata,
   input wire logic hready,
   input wire mwf_pkg::mwf_word_t hrdata
);
   import mwf_pkg::*;

   // ==========================================
   // Idle bus
   initial begin
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
   end

   // ==========================================
   // Single word transfer, waits on the slave with no assumed latency
   task automatic xfer(input logic wr, input logic [7:0] ofs, input mwf_word_t wd, output mwf_word_t rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, ofs};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      // Released data flips so a stale value is never mistaken for a held one
      hwdata <= ~wd;
   endtask

   // ==========================================
   // Consumer pop: read data is trusted only once read-side empty has dropped
   task automatic pop(output mwf_word_t rd);
      mwf_word_t st;
      st = 32'h00000001;
      while (st[`MWF_ST_RD_EMPTY] !== 1'b0) xfer(1'b0, `MWF_OFS_STATUS, 32'h00000000, st);
      xfer(1'b0, `MWF_OFS_RDATA, 32'h00000000, rd);
   endtask
endmodule // mwf_master

// [verif/mixed_width_dual_clock_fifo_test.sv]
// Self-checking testbench for the mixed-width FIFO block
`timescale 1ns/1ps
`include "mwf_params.svh"

module mixed_width_dual_clock_fifo_test;
   import mwf_pkg::*;

   logic hclk;
   logic hresetn;
   int mismatches;
   int checked;
   mwf_word_t d [16];

   // ==========================================
   // Clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // ==========================================
   // End 0: wide write, narrow read; end 1: narrow write, wide read
   for (genvar g = 0; g < 2; g++) begin : g_end
      logic hsel;
      logic hwrite;
      logic hreadyout;
      logic hresp;
      logic irq;
      mwf_word_t haddr;
      mwf_word_t hwdata;
      mwf_word_t hrdata;
      mwf_trans_t htrans;
      mwf_size_t hsize;
      mwf_top #(.WR_W(g == 0 ? 16 : 8), .RD_W(g == 0 ? 8 : 16), .DEPTH_U(16)) i_mwf_top (
         .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
         .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
         .hresp(hresp), .irq(irq));
      mwf_master i_mwf_master (
         .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
         .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
   end

   // ==========================================
   // Checking helpers
   task automatic chk(input string what, input mwf_word_t exp, input mwf_word_t got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus(input int s, input logic wr, input logic [7:0] ofs, input mwf_word_t wd, output mwf_word_t rd);
      if (s == 1) g_end[1].i_mwf_master.xfer(wr, ofs, wd, rd);
      else g_end[0].i_mwf_master.xfer(wr, ofs, wd, rd);
   endtask

   task automatic wr(input int s, input logic [7:0] ofs, input mwf_word_t wd);
      mwf_word_t r;
      bus(s, 1'b1, ofs, wd, r);
   endtask

   task automatic rd_chk(input int s, input logic [7:0] ofs, input string what, input mwf_word_t exp);
      mwf_word_t r;
      bus(s, 1'b0, ofs, 32'h00000000, r);
      chk(what, exp, r);
   endtask

   task automatic pop_chk(input int s, input string what, input mwf_word_t exp);
      mwf_word_t r;
      if (s == 1) g_end[1].i_mwf_master.pop(r);
      else g_end[0].i_mwf_master.pop(r);
      chk(what, exp, r);
   endtask

   // Pointers cross two synchroniser stages, so counts settle a few edges later
   task automatic settle();
      repeat (4) @(posedge hclk);
   endtask

   function automatic mwf_word_t exp_status(input int wu, input int ru, input int wmax, input int rmax);
      mwf_word_t s;
      s = 32'h00000000;
      s[`MWF_ST_RD_EMPTY] = (ru == 0);
      s[`MWF_ST_WR_FULL] = (wu == wmax);
      s[`MWF_ST_WR_EMPTY] = (wu == 0);
      s[`MWF_ST_RD_FULL] = (ru == rmax);
      s[15:8] = wu[7:0];
      s[23:16] = ru[7:0];
      return s;
   endfunction

   function automatic mwf_word_t slice8(input mwf_word_t w, input int i);
      return {24'h000000, w[8*i +: 8]};
   endfunction

   task automatic test_done();
      if (mismatches == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ==========================================
   // Watchdog
   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      test_done();
   end

   // ==========================================
   // Main sequence
   initial begin
      hresetn = 1'b0;
      mismatches = 0;
      checked = 0;
      void'($urandom(32'h6C13));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(0, `MWF_OFS_STATUS, "status after reset", exp_status(0, 0, 8, 16));
      rd_chk(1, `MWF_OFS_STATUS, "status after reset", exp_status(0, 0, 16, 8));
      rd_chk(0, 8'h18, "unmapped read", 32'h00000000);
      chk("response", 32'h00000000, {31'h0, g_end[0].hresp});
      // Wide write, narrow read; upper hwdata bits are random and must be dropped
      for (int i = 0; i < 2; i++) begin
         d[i] = $urandom;
         wr(0, `MWF_OFS_WDATA, d[i]);
      end
      settle();
      rd_chk(0, `MWF_OFS_STATUS, "wide status", exp_status(2, 4, 8, 16));
      for (int i = 0; i < 4; i++) pop_chk(0, "narrow read", slice8(d[i/2], i%2));
      chk("masked irq", 32'h00000000, {31'h0, g_end[0].irq});
      // Narrow write, wide read: empty holds over a partial word
      for (int i = 0; i < 4; i++) begin
         d[i] = $urandom;
         wr(1, `MWF_OFS_WDATA, d[i]);
         if (i == 0 || i == 2) begin
            settle();
            rd_chk(1, `MWF_OFS_STATUS, "partial status", exp_status(i + 1, (i + 1) / 2, 16, 8));
         end
      end
      settle();
      rd_chk(1, `MWF_OFS_STATUS, "packed status", exp_status(4, 2, 16, 8));
      for (int i = 0; i < 2; i++) pop_chk(1, "wide read", {16'h0000, d[2*i+1][7:0], d[2*i][7:0]});
      // Fill to refusal with full and overflow events unmasked
      wr(0, `MWF_OFS_IMASK, 32'h00000006);
      rd_chk(0, `MWF_OFS_IMASK, "mask readback", 32'h00000006);
      for (int i = 0; i < 9; i++) begin
         d[i] = $urandom;
         wr(0, `MWF_OFS_WDATA, d[i]);
      end
      settle();
      rd_chk(0, `MWF_OFS_STATUS, "full status", exp_status(8, 16, 8, 16));
      chk("irq on full", 32'h00000001, {31'h0, g_end[0].irq});
      rd_chk(0, `MWF_OFS_ISTAT, "events", 32'h00000007);
      settle();
      chk("irq after clear", 32'h00000000, {31'h0, g_end[0].irq});
      for (int i = 0; i < 16; i++) pop_chk(0, "drain", slice8(d[i/2], i%2));
      rd_chk(0, `MWF_OFS_RDATA, "empty read", 32'h00000000);
      rd_chk(0, `MWF_OFS_ISTAT, "underflow event", 32'h00000008);
      // Software clear in mid-stream, then fresh data from pointer zero
      for (int i = 0; i < 6; i++) begin
         d[i] = $urandom;
         if (i == 4) wr(1, `MWF_OFS_CTRL, 32'h00000001);
         wr(1, `MWF_OFS_WDATA, d[i]);
      end
      settle();
      rd_chk(1, `MWF_OFS_STATUS, "status after clear", exp_status(2, 1, 16, 8));
      pop_chk(1, "read after clear", {16'h0000, d[5][7:0], d[4][7:0]});
      // Reset pin in mid-run drops a stored word and the mask
      wr(0, `MWF_OFS_WDATA, $urandom);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(0, `MWF_OFS_STATUS, "status after reset pin", exp_status(0, 0, 8, 16));
      rd_chk(0, `MWF_OFS_IMASK, "mask after reset pin", 32'h00000000);
      test_done();
   end
endmodule // mixed_width_dual_clock_fifo_test
